// ---- hw/bhc_top.sv ----
// Hall-sensor commutation and dead-time protected power-stage modulator.
//
// Notes on behaviour
// RL1: Modulator counter and compare values are twelve bits wide.
// RL2: Six outputs, a high and low switch per half bridge.
// RL3: Pair never on together; programmable dead time between partners.
// RL4: Duty and period are programmable at run time.
// RL5: Timing registers take effect together at one cycle boundary.
// RL6: Fault input turns all six outputs off without software.
// RL7: Overcurrent fault comes from a comparator against a 10-bit reference.
// RL8: Pin or comparator Hall sources raise the same change event.
// RL9: Output pattern chosen only from current Hall value, on change.
// RL10: Centre-aligned counting mode is supported and is the reset mode.
// RL11: A compare value places the conversion trigger within the cycle.
// RL12: Modulator runs from a selectable 32 or 64 MHz rate.
// RL13: Fast decay modulates both high and low switch of the pair.
// RL14: Slow decay modulates high side, holds low side on.
// RL15: CW map 101 U-V, 001 U-W, 011 V-W, 010 V-U, 110 W-U, 100 W-V.
// RL16: Two windings energised per step; third half bridge fully off.
// RL17: Hall 000 or 111 turns all off and flags an error.
`timescale 1ns/1ps
module bhc_top
  import bhc_pkg::*;
#(
  parameter int CW  = bhc_pkg::CNT_W,
  parameter int DAW = bhc_pkg::DAC_W,
  parameter int DW  = bhc_pkg::DT_W
) (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_i,
  // Register port
  input  wire logic [bhc_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [31:0]                    reg_rdata_o,
  // Hall sensors, pin path and comparator path
  input  wire logic                      hall_input_first_i,
  input  wire logic                      hall_input_second_i,
  input  wire logic                      hall_input_third_i,
  input  wire logic [2:0]                hall_cmp_i,
  // Fault sources
  input  wire logic                      stage_fault_input_i,
  input  wire logic [bhc_pkg::DAC_W-1:0] current_code_i,
  // Power stage
  output logic                           phase_u_high_o,
  output logic                           phase_u_low_o,
  output logic                           phase_v_high_o,
  output logic                           phase_v_low_o,
  output logic                           phase_w_high_o,
  output logic                           phase_w_low_o,
  // Converter trigger
  output logic                           adc_trigger_o
);
  import bhc_pkg::*;

  initial begin
    if (CW != CNT_W || DAW != DAC_W || DW != DT_W)
      $error("Widths must match the register layout of the package.");
  end

  // ==========================================================================
  // Register file
  logic [CTRL_W-1:0] ctrl;
  bhc_timing_t       shadow;
  bhc_timing_t       active;
  logic [DAC_W-1:0]  dac_ref;
  logic              pending;
  logic              fault_flag;
  logic              hall_err;
  logic              hall_evt;
  logic [2:0]        hall_val;

  wire wr_ctrl   = reg_wr_i && reg_addr_i == REG_CTRL;
  wire wr_period = reg_wr_i && reg_addr_i == REG_PERIOD;
  wire wr_duty   = reg_wr_i && reg_addr_i == REG_DUTY;
  wire wr_dead   = reg_wr_i && reg_addr_i == REG_DEAD;
  wire wr_adc    = reg_wr_i && reg_addr_i == REG_ADC;
  wire wr_dac    = reg_wr_i && reg_addr_i == REG_DAC;
  wire wr_update = reg_wr_i && reg_addr_i == REG_UPDATE;
  wire wr_status = reg_wr_i && reg_addr_i == REG_STATUS;

  wire run       = ctrl[CTRL_RUN];
  wire centre    = ctrl[CTRL_CENTRE];
  wire fast      = ctrl[CTRL_FAST];
  wire pll64     = ctrl[CTRL_PLL64];
  wire hsrc_cmp  = ctrl[CTRL_HSRC];

  logic [31:0] status_word;
  logic [31:0] rd_mux;
  always_comb begin
    status_word = '0;
    status_word[ST_FAULT]   = fault_flag;
    status_word[ST_HALLERR] = hall_err;
    status_word[ST_HALLEVT] = hall_evt;
    status_word[ST_HALL_LO +: 3] = hall_val;
    status_word[ST_PEND]    = pending;
    unique case (reg_addr_i)
      REG_CTRL:   rd_mux = {{(32-CTRL_W){1'b0}}, ctrl};
      REG_PERIOD: rd_mux = {{(32-CNT_W){1'b0}}, shadow.period};
      REG_DUTY:   rd_mux = {{(32-CNT_W){1'b0}}, shadow.duty};
      REG_DEAD:   rd_mux = {{(32-DT_W){1'b0}}, shadow.dead};
      REG_ADC:    rd_mux = {{(32-CNT_W){1'b0}}, shadow.adc_cmp};
      REG_DAC:    rd_mux = {{(32-DAC_W){1'b0}}, dac_ref};
      REG_UPDATE: rd_mux = {31'h0000_0000, pending};
      REG_STATUS: rd_mux = status_word;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Timing writes land in the shadow set; none reaches the modulator until the
  // update request meets a cycle boundary. Writes to ctrl and dac_ref act at once.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctrl           <= CTRL_RST;
      shadow.period  <= PERIOD_RST;
      shadow.duty    <= DUTY_RST;
      shadow.dead    <= DEAD_RST;
      shadow.adc_cmp <= ADC_RST;
      dac_ref        <= DAC_RST;
      reg_rdata_o    <= 32'h0000_0000;
    end else begin
      if (wr_ctrl)   ctrl           <= reg_wdata_i[CTRL_W-1:0];
      if (wr_period) shadow.period  <= reg_wdata_i[CNT_W-1:0]; // [RL4]
      if (wr_duty)   shadow.duty    <= reg_wdata_i[CNT_W-1:0]; // [RL4]
      if (wr_dead)   shadow.dead    <= reg_wdata_i[DT_W-1:0]; // [RL3]
      if (wr_adc)    shadow.adc_cmp <= reg_wdata_i[CNT_W-1:0]; // [RL11]
      if (wr_dac)    dac_ref        <= reg_wdata_i[DAC_W-1:0]; // [RL7]
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Modulator rate: fractional divider gives a 32 or 64 MHz tick enable.
  logic [7:0] rate_acc;
  logic       tick;
  wire  [8:0] rate_step = pll64 ? PLL_HIGH_MHZ : PLL_LOW_MHZ; // [RL12]
  wire  [8:0] rate_sum  = {1'b0, rate_acc} + rate_step;
  wire        rate_wrap = rate_sum >= SYS_CLK_MHZ;
  wire  [8:0] rate_left = rate_sum - SYS_CLK_MHZ;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rate_acc <= 8'h00;
      tick     <= 1'b0;
    end else begin
      rate_acc <= rate_wrap ? rate_left[7:0] : rate_sum[7:0]; // [RL12]
      tick     <= rate_wrap;
    end
  end

  // ==========================================================================
  // Twelve-bit counter, centre-aligned or edge-aligned.
  logic [CNT_W-1:0] cnt;
  logic             down;
  wire cyc_end  = tick && cnt == '0 && !down;
  wire at_top   = cnt >= active.period;
  wire pwm_on   = cnt < active.duty; // [RL1]
  wire adc_hit  = tick && cnt == active.adc_cmp && !down;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt  <= '0;
      down <= 1'b0;
    end else if (tick) begin
      if (down) begin
        cnt  <= cnt - 1'b1; // [RL10]
        down <= cnt > 12'h0_001;
      end else if (at_top) begin
        if (centre && cnt != '0) begin
          cnt  <= cnt - 1'b1; // [RL10]
          down <= cnt > 12'h0_001;
        end else begin
          cnt <= '0; // [RL1]
        end
      end else begin
        cnt <= cnt + 1'b1; // [RL1]
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      active.period  <= PERIOD_RST;
      active.duty    <= DUTY_RST;
      active.dead    <= DEAD_RST;
      active.adc_cmp <= ADC_RST;
      pending        <= 1'b0;
      adc_trigger_o  <= 1'b0;
    end else begin
      if (cyc_end && pending) active <= shadow; // [RL5]
      if (wr_update) pending <= 1'b1;
      else if (cyc_end) pending <= 1'b0; // [RL5]
      adc_trigger_o <= adc_hit; // [RL11]
    end
  end

  // ==========================================================================
  // Input synchronisers for asynchronous pins and comparators.
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] cmp_s1;
  logic [2:0] cmp_s2;
  logic       flt_s1;
  logic       flt_s2;
  wire  [2:0] pin_raw = {hall_input_third_i, hall_input_second_i,
                         hall_input_first_i};

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      cmp_s1 <= 3'h0;
      cmp_s2 <= 3'h0;
      flt_s1 <= 1'b0;
      flt_s2 <= 1'b0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      cmp_s1 <= hall_cmp_i;
      cmp_s2 <= cmp_s1;
      flt_s1 <= stage_fault_input_i;
      flt_s2 <= flt_s1;
    end
  end

  // ==========================================================================
  // Hall value, change event and illegal-code flag.
  wire [2:0] hall_now = hsrc_cmp ? cmp_s2 : pin_s2; // [RL8]
  wire       hall_chg = hall_now != hall_val;
  wire       hall_bad = hall_now == 3'h0 || hall_now == 3'h7;
  wire       evt_clr  = wr_status && reg_wdata_i[ST_HALLEVT];

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hall_val <= 3'h0;
      hall_evt <= 1'b0;
      hall_err <= 1'b0;
    end else begin
      hall_val <= hall_now; // [RL9]
      if (hall_chg) hall_evt <= 1'b1; // [RL8]
      else if (evt_clr) hall_evt <= 1'b0;
      hall_err <= hall_bad; // [RL17]
    end
  end

  // ==========================================================================
  // Fault: pin or overcurrent comparator, latched until software clears it.
  // The set side wins, so a fault still present keeps the flag up.
  wire over_current = current_code_i > dac_ref; // [RL7]
  wire fault_now    = flt_s2 | over_current; // [RL6]
  wire fault_clr    = wr_status && reg_wdata_i[ST_FAULT];

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) fault_flag <= 1'b0;
    else if (fault_now) fault_flag <= 1'b1; // [RL6]
    else if (fault_clr) fault_flag <= 1'b0;
  end

  // ==========================================================================
  // Commutation table, clockwise; bit order of each field is W, V, U.
  bhc_bridge_t conn;
  always_comb begin
    unique case (hall_val) // [RL9]
      3'b101:  conn = '{high: 3'b001, low: 3'b010}; // [RL15]
      3'b001:  conn = '{high: 3'b001, low: 3'b100}; // [RL15]
      3'b011:  conn = '{high: 3'b010, low: 3'b100}; // [RL15]
      3'b010:  conn = '{high: 3'b010, low: 3'b001}; // [RL15]
      3'b110:  conn = '{high: 3'b100, low: 3'b001}; // [RL15]
      3'b100:  conn = '{high: 3'b100, low: 3'b010}; // [RL15]
      default: conn = '{high: 3'b000, low: 3'b000}; // [RL17]
    endcase
  end

  // Slow decay holds the low switch on for the whole step so the winding
  // current recirculates through it; fast decay chops both switches.
  wire       lo_pwm  = fast ? pwm_on : 1'b1; // [RL13] [RL14]
  wire [2:0] want_hi = conn.high & {3{pwm_on}}; // [RL13]
  wire [2:0] want_lo = conn.low & {3{lo_pwm}}; // [RL14]
  wire       kill    = fault_now | fault_flag | hall_err | ~run; // [RL6]

  // ==========================================================================
  // Three half bridges.
  logic [2:0] sw_hi;
  logic [2:0] sw_lo;
  for (genvar i = 0; i < 3; i++) begin : g_leg
    bhc_dead_time #(
      .DW (DT_W)
    ) u_leg (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .tick_i    (tick),
      .dead_i    (active.dead),
      .kill_i    (kill),
      .want_hi_i (want_hi[i]),
      .want_lo_i (want_lo[i]),
      .hi_o      (sw_hi[i]),
      .lo_o      (sw_lo[i])
    ); // [RL2] [RL16]
  end

  assign phase_u_high_o = sw_hi[0];
  assign phase_u_low_o  = sw_lo[0];
  assign phase_v_high_o = sw_hi[1];
  assign phase_v_low_o  = sw_lo[1];
  assign phase_w_high_o = sw_hi[2];
  assign phase_w_low_o  = sw_lo[2];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_update_armed;
    wr_update ##1 pending;
  endsequence

  a_fault_kills: assert property (fault_now |=> (sw_hi | sw_lo) == 3'h0) // [RL6]
    else $error("Outputs stayed on while a fault was present.");
  a_over_current: assert property ( // [RL7]
      current_code_i > dac_ref |=> fault_flag)
    else $error("Overcurrent did not latch the fault flag.");
  a_illegal_hall: assert property ( // [RL17]
      hall_err |-> ##1 (sw_hi | sw_lo) == 3'h0)
    else $error("Outputs on during an illegal Hall value.");
  a_hall_event: assert property (hall_chg |=> hall_evt) // [RL8]
    else $error("Hall change did not raise the event flag.");
  a_commit_sync: assert property ( // [RL5]
      active != $past(active) |-> $past(cyc_end && pending))
    else $error("Timing changed away from a cycle boundary.");
  a_update_hold: assert property ( // [RL5]
      s_update_armed ##0 !cyc_end |=> pending)
    else $error("Pending update lost before the boundary.");
  a_adc_trigger: assert property ( // [RL11]
      adc_hit |=> adc_trigger_o ##1 !adc_trigger_o)
    else $error("Converter trigger missed or longer than one cycle.");
  a_count_range: assert property ( // [RL1]
      tick && !down && cnt < active.period |=> cnt == $past(cnt) + 1'b1)
    else $error("Counter did not advance on a tick.");
  a_map_uv: assert property ( // [RL15]
      hall_val == 3'b101 |-> conn.high == 3'b001 && conn.low == 3'b010)
    else $error("Hall 101 did not select U high, V low.");
  a_two_windings: assert property ( // [RL16]
      !hall_err && !hall_bad |-> $countones(conn.high | conn.low) == 2 ||
      hall_val == 3'h0 || hall_val == 3'h7)
    else $error("Commutation step does not energise exactly two legs.");
  a_slow_decay: assert property ( // [RL14]
      !fast && !kill |-> want_lo == conn.low)
    else $error("Slow decay did not hold the low switch on.");
  a_fast_decay: assert property ( // [RL13]
      fast && !pwm_on |-> want_lo == 3'h0 && want_hi == 3'h0)
    else $error("Fast decay left a switch requested in the off time.");

endmodule : bhc_top

// ---- hw/bhc_pkg.sv ----
// Package with register map, field layout and timing constants of the block.
package bhc_pkg;

  // ==========================================================================
  // Widths
  localparam int CNT_W  = 12;
  localparam int DAC_W  = 10;
  localparam int DT_W   = 8;
  localparam int ADDR_W = 8;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PERIOD = 8'h04;
  localparam logic [7:0] REG_DUTY   = 8'h08;
  localparam logic [7:0] REG_DEAD   = 8'h0C;
  localparam logic [7:0] REG_ADC    = 8'h10;
  localparam logic [7:0] REG_DAC    = 8'h14;
  localparam logic [7:0] REG_UPDATE = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  // ==========================================================================
  // Control bit positions
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_CENTRE = 1;
  localparam int CTRL_FAST   = 2;
  localparam int CTRL_PLL64  = 3;
  localparam int CTRL_HSRC   = 4;
  localparam int CTRL_W      = 5;

  // ==========================================================================
  // Status bit positions
  localparam int ST_FAULT   = 0;
  localparam int ST_HALLERR = 1;
  localparam int ST_HALLEVT = 2;
  localparam int ST_HALL_LO = 4;
  localparam int ST_PEND    = 7;

  // ==========================================================================
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h02;
  localparam logic [CNT_W-1:0]  PERIOD_RST = 12'h0_0FA;
  localparam logic [CNT_W-1:0]  DUTY_RST   = 12'h0_000;
  localparam logic [DT_W-1:0]   DEAD_RST   = 8'h04;
  localparam logic [CNT_W-1:0]  ADC_RST    = 12'h0_000;
  localparam logic [DAC_W-1:0]  DAC_RST    = 10'h3FF;

  // ==========================================================================
  // Modulator clock synthesis from the system clock
  localparam logic [8:0] SYS_CLK_MHZ  = 9'd200;
  localparam logic [8:0] PLL_LOW_MHZ  = 9'd32;
  localparam logic [8:0] PLL_HIGH_MHZ = 9'd64;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] duty;
    logic [DT_W-1:0]  dead;
    logic [CNT_W-1:0] adc_cmp;
  } bhc_timing_t;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } bhc_bridge_t;

endpackage : bhc_pkg

// ---- hw/bhc_dead_time.sv ----
// One half bridge: complementary switch pair with dead-time insertion.
`timescale 1ns/1ps
module bhc_dead_time
  import bhc_pkg::*;
#(
  parameter int DW = bhc_pkg::DT_W
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          reset_i,
  // Timing
  input  wire logic          tick_i,
  input  wire logic [DW-1:0] dead_i,
  input  wire logic          kill_i,
  // Requests and switch drives
  input  wire logic          want_hi_i,
  input  wire logic          want_lo_i,
  output logic               hi_o,
  output logic               lo_o
);
  logic          last_hi;
  logic          last_lo;
  logic [DW-1:0] gap;
  wire           gap_ok    = gap >= dead_i;
  wire           next_hi   = want_hi_i & ~lo_o & ~kill_i & (last_hi | gap_ok);
  wire           next_lo   = want_lo_i & ~hi_o & ~kill_i & (last_lo | gap_ok);
  wire           both_off  = ~hi_o & ~lo_o;
  wire           gap_full  = &gap;

  // A switch may come back at once after its own pulse, but never before the
  // partner has been off for the whole dead time.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hi_o    <= 1'b0;
      lo_o    <= 1'b0;
      last_hi <= 1'b0;
      last_lo <= 1'b0;
      gap     <= '0;
    end else begin
      hi_o <= next_hi; // [RL3]
      lo_o <= next_lo; // [RL3]
      if (kill_i) begin
        last_hi <= 1'b0;
        last_lo <= 1'b0;
      end else if (hi_o | lo_o) begin
        last_hi <= hi_o;
        last_lo <= lo_o;
      end
      if (!both_off || kill_i) gap <= '0;
      else if (tick_i && !gap_full) gap <= gap + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_pair_exclusive: assert property (!(hi_o && lo_o)) // [RL3]
    else $error("Both switches of one half bridge are on.");
  a_dead_gap: assert property ($rose(lo_o) |-> $past(!hi_o)) // [RL3]
    else $error("Low switch rose without a gap after the high switch.");

endmodule : bhc_dead_time

// ---- tb/bhc_stage_model.sv ----
// Hall sensor and three half-bridge power stage model.
`timescale 1ns/1ps
module bhc_stage_model
  import bhc_pkg::*;
(
  // Clock
  input  wire logic                 sys_clk_i,
  // Rotor position and selected sensor path
  input  wire logic [2:0]           hall_i,
  input  wire logic                 cmp_sel_i,
  // Bridge drives
  input  wire bhc_pkg::bhc_bridge_t bridge_i,
  // Sensor outputs
  output logic                      hall_sensor_one_o,
  output logic                      hall_sensor_two_o,
  output logic                      hall_sensor_three_o,
  output logic [2:0]                hall_cmp_o,
  // Shoot-through events seen on the legs
  output int                        shorts_o
);
  import bhc_pkg::*;

  // ==========================================================================
  // Sensor paths
  // The unused path carries the inverse, so a wrong source pick shows up.
  assign {hall_sensor_three_o, hall_sensor_two_o, hall_sensor_one_o} =
    cmp_sel_i ? ~hall_i : hall_i;
  assign hall_cmp_o = cmp_sel_i ? hall_i : ~hall_i;

  // ==========================================================================
  // Leg monitor
  // A switch closing in the same cycle its partner opens still shorts the
  // supply through the slow turn-off of real transistors.
  bhc_bridge_t last = '0;
  initial shorts_o = 0;
  always @(posedge sys_clk_i) begin
    if (((bridge_i.high & bridge_i.low) | (bridge_i.high & last.low) |
         (bridge_i.low & last.high)) != 3'b000) begin
      shorts_o <= shorts_o + 1;
    end
    last <= bridge_i;
  end
endmodule : bhc_stage_model

// ---- tb/tb_bldc_hall_commutation_pwm.sv ----
// Self-checking bench for the Hall commutation and modulator block.
`timescale 1ns/1ps
module tb_bldc_hall_commutation_pwm;
  import bhc_pkg::*;

  // ==========================================================================
  // Signals
  logic        sys_clk_i   = 1'b0;
  logic        reset_i     = 1'b1;
  logic [7:0]  reg_addr    = 8'h00;
  logic [31:0] reg_wdata   = 32'h0000_0000;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [2:0]  hall        = 3'b101;
  logic        hall_src    = 1'b0;
  logic        fault_pin   = 1'b0;
  logic [9:0]  cur_code    = 10'h000;
  logic [31:0] reg_rdata;
  logic [31:0] rv;
  logic        h1;
  logic        h2;
  logic        h3;
  logic        adc_trig;
  logic [2:0]  hall_cmp;
  wire  [5:0]  legs;
  bhc_bridge_t bridge;
  int          shorts;
  int          failures    = 0;
  int          checks_done = 0;
  int          seed        = 32'h4c41bd29;

  assign bridge = legs;
  always #2.5 sys_clk_i = ~sys_clk_i;

  bhc_top u_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .hall_input_first_i(h1),
    .hall_input_second_i(h2), .hall_input_third_i(h3),
    .hall_cmp_i(hall_cmp), .stage_fault_input_i(fault_pin),
    .current_code_i(cur_code), .phase_u_high_o(legs[5]),
    .phase_v_high_o(legs[4]), .phase_w_high_o(legs[3]),
    .phase_u_low_o(legs[2]), .phase_v_low_o(legs[1]),
    .phase_w_low_o(legs[0]), .adc_trigger_o(adc_trig));

  bhc_stage_model u_stage (
    .sys_clk_i(sys_clk_i), .hall_i(hall), .cmp_sel_i(hall_src),
    .bridge_i(bridge), .hall_sensor_one_o(h1), .hall_sensor_two_o(h2),
    .hall_sensor_three_o(h3), .hall_cmp_o(hall_cmp), .shorts_o(shorts));

  // ==========================================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rd_chk

  // ==========================================================================
  // Expectations
  function automatic bhc_bridge_t exp_legs(input logic [2:0] h,
                                           input logic fast, input logic on);
    bhc_bridge_t b;
    case (h)
      3'b101: b = {3'b100, 3'b010};
      3'b001: b = {3'b100, 3'b001};
      3'b011: b = {3'b010, 3'b001};
      3'b010: b = {3'b010, 3'b100};
      3'b110: b = {3'b001, 3'b100};
      3'b100: b = {3'b001, 3'b010};
      default: b = '0;
    endcase
    b.high = b.high & {3{on}};
    b.low  = b.low & {3{on | ~fast}};
    return b;
  endfunction : exp_legs

  task automatic setmode(input logic [31:0] ctrl);
    wr(REG_CTRL, ctrl);
    hall_src <= ctrl[CTRL_HSRC];
    repeat (10) @(posedge sys_clk_i);
    wr(REG_STATUS, 32'h0000_0004);
  endtask : setmode

  task automatic step(input logic [2:0] h, input logic fast, input logic on);
    logic ev;
    ev = (h != hall);
    hall <= h;
    repeat (80) @(posedge sys_clk_i);
    check(32'(bridge), 32'(exp_legs(h, fast, on)));
    rd(REG_STATUS, rv);
    check(32'(rv[ST_HALLERR]), 32'(h == 3'b000 || h == 3'b111));
    check(32'(rv[ST_HALL_LO +: 3]), 32'(h));
    check(32'(rv[ST_HALLEVT]), 32'(ev));
    wr(REG_STATUS, 32'h0000_0004);
  endtask : step

  task automatic commit(input logic [11:0] p, input logic [11:0] d,
                        input logic [11:0] a);
    int n;
    wr(REG_PERIOD, 32'(p));
    wr(REG_DUTY, 32'(d));
    wr(REG_ADC, 32'(a));
    wr(REG_UPDATE, 32'h0000_0001);
    n = 0;
    rv = 32'h0000_0001;
    while (rv[0] && n < 2000) begin
      rd(REG_UPDATE, rv);
      n++;
    end
    check(rv, 32'h0000_0000);
  endtask : commit

  // Counts triggers and high-side on time; slow decay keeps short pulses.
  task automatic measure(input logic [31:0] ctrl);
    int n;
    int hon;
    int e;
    setmode(ctrl);
    repeat (300) @(posedge sys_clk_i);
    n = 0;
    hon = 0;
    repeat (4000) begin
      @(negedge sys_clk_i);
      n += int'(adc_trig);
      hon += int'(|bridge.high);
    end
    e = 4000 * (ctrl[CTRL_PLL64] ? 64 : 32) /
        (200 * (ctrl[CTRL_CENTRE] ? 40 : 21));
    check(32'(n >= e - 1 && n <= e + 1), 32'h0000_0001);
    check(32'(hon > 0 && hon < 4000), 32'h0000_0001);
  endtask : measure

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    failures++;
    print_verdict();
  end

  initial begin
    logic [9:0] dv;
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd_chk(REG_CTRL, 32'(CTRL_RST));
    rd_chk(REG_PERIOD, 32'(PERIOD_RST));
    rd_chk(REG_DUTY, 32'(DUTY_RST));
    rd_chk(REG_DEAD, 32'(DEAD_RST));
    rd_chk(REG_ADC, 32'(ADC_RST));
    rd_chk(REG_DAC, 32'(DAC_RST));
    rd_chk(8'h20, 32'h0000_0000);
    setmode(32'h0000_0003);
    wr(REG_DUTY, 32'h0000_0FFF);
    rd_chk(REG_DUTY, 32'h0000_0FFF);
    rd_chk(REG_UPDATE, 32'h0000_0000);
    repeat (80) @(posedge sys_clk_i);
    check(32'(bridge), 32'(exp_legs(3'b101, 1'b0, 1'b0)));
    wr(REG_UPDATE, 32'h0000_0001);
    rd_chk(REG_UPDATE, 32'h0000_0001);
    commit(12'h0FA, 12'hFFF, 12'h000);
    for (int f = 0; f < 2; f++) begin
      setmode(32'h0000_0003 | (f << CTRL_FAST));
      for (int h = 0; h < 8; h++) step(3'(h), f[0], 1'b1);
    end
    commit(12'h0FA, 12'h000, 12'h000);
    for (int f = 0; f < 2; f++) begin
      setmode(32'h0000_0003 | (f << CTRL_FAST));
      repeat (3) step(3'($random(seed)), f[0], 1'b0);
    end
    setmode(32'h0000_0003);
    step(3'b101, 1'b0, 1'b0);
    fault_pin <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    check(32'(bridge), 32'h0000_0000);
    fault_pin <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rd_chk(REG_STATUS, 32'h0000_0051);
    wr(REG_STATUS, 32'h0000_0001);
    repeat (80) @(posedge sys_clk_i);
    check(32'(bridge), 32'(exp_legs(3'b101, 1'b0, 1'b0)));
    dv = 10'($random(seed)) & 10'h3FE;
    wr(REG_DAC, 32'(dv));
    cur_code <= dv;
    repeat (5) @(posedge sys_clk_i);
    rd_chk(REG_STATUS, 32'h0000_0050);
    cur_code <= dv + 10'h001;
    repeat (3) @(posedge sys_clk_i);
    check(32'(bridge), 32'h0000_0000);
    cur_code <= 10'h000;
    repeat (3) @(posedge sys_clk_i);
    wr(REG_STATUS, 32'h0000_0001);
    setmode(32'h0000_0013);
    repeat (4) step(3'($random(seed)), 1'b0, 1'b0);
    hall <= 3'b101;
    rv = $random(seed);
    dv = 10'(1 + rv % 19);
    rv = $random(seed);
    commit(12'h014, 12'(dv), 12'(1 + rv % 19));
    measure(32'h0000_0003);
    measure(32'h0000_000B);
    measure(32'h0000_0001);
    measure(32'h0000_0009);
    check(32'(shorts), 32'h0000_0000);
    print_verdict();
  end
endmodule : tb_bldc_hall_commutation_pwm
